// >>> hdl/lbc_pkg.sv
// Shared constants for the LED buck configuration link: frame layout,
// device register map, controller register map and link timing.
// Assumes both ends run from the same 20 MHz mclk.
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
package lbc_pkg;
   // ------------------------------------------------------------------
   // Link frame layout.
   // ------------------------------------------------------------------
   localparam int FRAME_BITS = 16;
   localparam int FRAME_WR_BIT = 15;
   localparam int ADDR_BITS = 7;
   localparam int DATA_BITS = 8;
   localparam logic [4:0] CNT_ADDR_DONE = 5'h07;
   localparam logic [4:0] CNT_DATA_START = 5'h08;
   localparam logic [4:0] CNT_FRAME_LAST = 5'h0F;
   localparam logic [4:0] CNT_FRAME_FULL = 5'h10;
   // ------------------------------------------------------------------
   // Device register map.
   // ------------------------------------------------------------------
   localparam logic [6:0] ADDR_TARGET_CH1 = 7'h02;
   localparam logic [6:0] ADDR_TARGET_CH2 = 7'h03;
   localparam logic [6:0] ADDR_TARGET_CH3 = 7'h04;
   localparam logic [6:0] ADDR_RANGE = 7'h05;
   localparam logic [6:0] ADDR_RIPPLE_CH1 = 7'h0B;
   localparam logic [6:0] ADDR_RIPPLE_CH2 = 7'h0C;
   localparam logic [6:0] ADDR_RIPPLE_CH3 = 7'h0D;
   localparam logic [6:0] ADDR_UV_THRESHOLD = 7'h0F;
   localparam logic [6:0] ADDR_SUPPLY_LEVEL = 7'h38;
   localparam logic [7:0] RANGE_MASK = 8'h07;
   localparam logic [7:0] RIPPLE_MASK = 8'h03;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;
   // ------------------------------------------------------------------
   // Controller register map on AHB-Lite.
   // ------------------------------------------------------------------
   localparam logic [7:0] OFS_CMD = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
   localparam logic [7:0] OFS_IRQ_CLEAR = 8'h0C;
   localparam logic [7:0] OFS_IRQ_ENABLE = 8'h10;
   localparam int STATUS_BUSY_BIT = 0;
   localparam int STATUS_RDATA_LSB = 8;
   localparam int IRQ_DONE_BIT = 0;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'b0;
   // ------------------------------------------------------------------
   // Link timing: half a link clock period in mclk cycles.
   // ------------------------------------------------------------------
   localparam int MCLK_HZ = 20_000_000;
   localparam int LINK_HALF_NS = 400;
   localparam int LINK_HALF_CYC = (LINK_HALF_NS * (MCLK_HZ / 1_000_000)) / 1000;
   typedef enum logic [1:0] {
      LBC_IDLE = 2'b00,
      LBC_SETUP = 2'b01,
      LBC_SHIFT = 2'b10,
      LBC_END = 2'b11
   } lbc_state_t;
endpackage : lbc_pkg

// >>> hdl/lbc_link_if.sv
// Four-wire serial link between the controller and the LED driver.
// Assumes the testbench instantiates it and connects both ends.
interface lbc_link_if;
   logic sclk;
   logic csb_n;
   logic sdi;
   logic sdo;
   modport dev (input sclk, input csb_n, input sdi, output sdo);
   modport host (output sclk, output csb_n, output sdi, input sdo);
endinterface : lbc_link_if

// >>> hdl/lbc_dev.sv
// Driver end: link slave, configuration registers and channel gating.
// Assumes link pins and dimming inputs are asynchronous to mclk.
module lbc_dev
   import lbc_pkg::*;
(
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst_n,
   // Link.
   lbc_link_if.dev link,
   // Measurement and dimming.
   input wire logic [7:0] supply_level_code,
   input wire logic [2:0] dim_input,
   input wire logic [2:0] dim_ctrl_en,
   // Configuration outputs.
   output logic [7:0] target_code_first,
   output logic [7:0] target_code_second,
   output logic [7:0] target_code_third,
   output logic range_sel_first,
   output logic range_sel_second,
   output logic range_sel_third,
   output logic [1:0] ripple_sel_first,
   output logic [1:0] ripple_sel_second,
   output logic [1:0] ripple_sel_third,
   output logic [7:0] uv_threshold_value,
   // Status and gates.
   output logic supply_above_uv_flag,
   output logic [2:0] gate_drive_out,
   output logic link_error
);
   // ------------------------------------------------------------------
   // Input synchronisers.
   // ------------------------------------------------------------------
   logic [5:0] sync1;
   logic [5:0] sync2;
   logic sclk_d;
   logic sclk_s;
   logic csb_s;
   logic sdi_s;
   logic [2:0] dim_s;
   logic rise;
   logic fall;
   localparam logic [5:0] SYNC_IDLE = 6'h02;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sync1 <= SYNC_IDLE;
         sync2 <= SYNC_IDLE;
         sclk_d <= 1'b0;
      end else begin
         sync1 <= {dim_input, link.sdi, link.csb_n, link.sclk};
         sync2 <= sync1;
         sclk_d <= sync2[0];
      end
   end
   assign sclk_s = sync2[0];
   assign csb_s = sync2[1];
   assign sdi_s = sync2[2];
   assign dim_s = sync2[5:3];
   assign rise = sclk_s & ~sclk_d & ~csb_s;
   assign fall = ~sclk_s & sclk_d & ~csb_s;
   // ------------------------------------------------------------------
   // Register store.
   // ------------------------------------------------------------------
   logic [7:0] tgt [3];
   logic [2:0] rng;
   logic [1:0] rip [3];
   logic [7:0] uv_thr;
   logic [14:0] rx;
   logic [4:0] cnt;
   logic [7:0] tx;
   logic [15:0] frame;
   assign frame = {rx, sdi_s};
   function automatic logic [7:0] rd_mux(input logic [6:0] a);
      logic [7:0] r;
      r = READ_UNMAPPED;
      case (a)
         ADDR_TARGET_CH1: r = tgt[0];
         ADDR_TARGET_CH2: r = tgt[1];
         ADDR_TARGET_CH3: r = tgt[2];
         ADDR_RANGE: r = {5'h00, rng};
         ADDR_RIPPLE_CH1: r = {6'h00, rip[0]};
         ADDR_RIPPLE_CH2: r = {6'h00, rip[1]};
         ADDR_RIPPLE_CH3: r = {6'h00, rip[2]};
         ADDR_UV_THRESHOLD: r = uv_thr;
         ADDR_SUPPLY_LEVEL: r = supply_level_code;
         default: r = READ_UNMAPPED;
      endcase
      return r;
   endfunction : rd_mux
   // Writes commit at the last rising link edge and apply at once.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 3; i++) begin
            tgt[i] <= REG_RESET;
            rip[i] <= 2'h0;
         end
         rng <= 3'h0;
         uv_thr <= REG_RESET;
         link_error <= 1'b0;
      end else if (rise && cnt == CNT_FRAME_LAST && frame[FRAME_WR_BIT]) begin
         case (frame[14:8])
            ADDR_TARGET_CH1: tgt[0] <= frame[7:0];
            ADDR_TARGET_CH2: tgt[1] <= frame[7:0];
            ADDR_TARGET_CH3: tgt[2] <= frame[7:0];
            ADDR_RANGE: rng <= frame[2:0] & RANGE_MASK[2:0];
            ADDR_RIPPLE_CH1: rip[0] <= frame[1:0] & RIPPLE_MASK[1:0];
            ADDR_RIPPLE_CH2: rip[1] <= frame[1:0] & RIPPLE_MASK[1:0];
            ADDR_RIPPLE_CH3: rip[2] <= frame[1:0] & RIPPLE_MASK[1:0];
            ADDR_UV_THRESHOLD: uv_thr <= frame[7:0];
            ADDR_SUPPLY_LEVEL: link_error <= link_error;
            default: link_error <= 1'b1;
         endcase
      end
   end
   // ------------------------------------------------------------------
   // Link shifter.
   // ------------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rx <= 15'h0000;
         cnt <= 5'h00;
         tx <= 8'h00;
         link.sdo <= 1'b0;
      end else if (csb_s) begin
         cnt <= 5'h00;
         link.sdo <= 1'b0;
      end else if (rise && cnt != CNT_FRAME_FULL) begin
         rx <= frame[14:0];
         cnt <= cnt + 5'h01;
         if (cnt == CNT_ADDR_DONE) begin
            tx <= rd_mux(frame[6:0]);
         end
      end else if (fall && cnt >= CNT_DATA_START && cnt != CNT_FRAME_FULL) begin
         link.sdo <= tx[7];
         tx <= {tx[6:0], 1'b0};
      end
   end
   // ------------------------------------------------------------------
   // Outputs and channel gating.
   // ------------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         supply_above_uv_flag <= 1'b0;
         gate_drive_out <= 3'h0;
      end else begin
         supply_above_uv_flag <= supply_level_code > uv_thr;
         gate_drive_out <= dim_s & dim_ctrl_en & {3{supply_level_code > uv_thr}};
      end
   end
   assign target_code_first = tgt[0];
   assign target_code_second = tgt[1];
   assign target_code_third = tgt[2];
   assign range_sel_first = rng[0];
   assign range_sel_second = rng[1];
   assign range_sel_third = rng[2];
   assign ripple_sel_first = rip[0];
   assign ripple_sel_second = rip[1];
   assign ripple_sel_third = rip[2];
   assign uv_threshold_value = uv_thr;
endmodule : lbc_dev

// >>> hdl/lbc_host.sv
// Controller end: AHB-Lite register slave that runs link frames.
// Assumes the single AHB master sees hreadyout as hready.
module lbc_host
   import lbc_pkg::*;
#(
   parameter int HALF = LINK_HALF_CYC
)(
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst_n,
   // AHB-Lite slave.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Interrupt.
   output logic irq,
   // Link.
   lbc_link_if.host link
);
   // ------------------------------------------------------------------
   // Bus slave and registers.
   // ------------------------------------------------------------------
   logic wr_pend;
   logic [7:0] wr_ofs;
   logic [15:0] cmd;
   logic start;
   logic busy;
   logic done;
   logic [7:0] rd_data;
   logic irq_stat;
   logic irq_en;
   logic [31:0] rd_word;
   lbc_state_t state;
   assign hreadyout = 1'b1;
   assign hresp = HRESP_OKAY;
   assign busy = state != LBC_IDLE;
   always_comb begin
      rd_word = 32'h0000_0000;
      case (haddr[7:0])
         OFS_STATUS: begin
            rd_word[STATUS_BUSY_BIT] = busy;
            rd_word[STATUS_RDATA_LSB +: 8] = rd_data;
         end
         OFS_IRQ_STATUS: rd_word[IRQ_DONE_BIT] = irq_stat;
         OFS_IRQ_ENABLE: rd_word[IRQ_DONE_BIT] = irq_en;
         default: rd_word = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wr_pend <= 1'b0;
         wr_ofs <= 8'h00;
         hrdata <= 32'h0000_0000;
      end else if (hready) begin
         wr_pend <= hsel && htrans == HTRANS_NONSEQ && hwrite;
         wr_ofs <= haddr[7:0];
         if (hsel && htrans == HTRANS_NONSEQ && !hwrite) begin
            hrdata <= rd_word;
         end
      end
   end
   assign start = wr_pend && wr_ofs == OFS_CMD && !busy;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat <= 1'b0;
         irq_en <= 1'b0;
      end else begin
         if (wr_pend && wr_ofs == OFS_IRQ_ENABLE) begin
            irq_en <= hwdata[IRQ_DONE_BIT];
         end
         if (done) begin
            irq_stat <= 1'b1;
         end else if (wr_pend && wr_ofs == OFS_IRQ_CLEAR && hwdata[IRQ_DONE_BIT]) begin
            irq_stat <= 1'b0;
         end
      end
   end
   assign irq = irq_stat & irq_en;
   // ------------------------------------------------------------------
   // Link frame engine.
   // ------------------------------------------------------------------
   logic [7:0] div;
   logic tick;
   logic [3:0] bitn;
   logic [1:0] sdo_sync;
   assign tick = div == 8'(HALF - 1);
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sdo_sync <= 2'h0;
      end else begin
         sdo_sync <= {sdo_sync[0], link.sdo};
      end
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state <= LBC_IDLE;
         div <= 8'h00;
         bitn <= 4'h0;
         cmd <= 16'h0000;
         rd_data <= 8'h00;
         done <= 1'b0;
         link.sclk <= 1'b0;
         link.csb_n <= 1'b1;
         link.sdi <= 1'b0;
      end else begin
         done <= 1'b0;
         div <= (busy && !tick) ? div + 8'h01 : 8'h00;
         case (state)
            LBC_IDLE: begin
               if (start) begin
                  cmd <= hwdata[15:0];
                  link.csb_n <= 1'b0;
                  link.sdi <= hwdata[FRAME_WR_BIT];
                  bitn <= 4'h0;
                  state <= LBC_SETUP;
               end
            end
            LBC_SETUP: begin
               if (tick) begin
                  link.sclk <= 1'b1;
                  rd_data <= {rd_data[6:0], sdo_sync[1]};
                  state <= LBC_SHIFT;
               end
            end
            LBC_SHIFT: begin
               if (tick) begin
                  link.sclk <= 1'b0;
                  if (bitn == 4'hF) begin
                     state <= LBC_END;
                  end else begin
                     bitn <= bitn + 4'h1;
                     link.sdi <= cmd[4'hE - bitn];
                     state <= LBC_SETUP;
                  end
               end
            end
            LBC_END: begin
               if (tick) begin
                  link.csb_n <= 1'b1;
                  done <= 1'b1;
                  state <= LBC_IDLE;
               end
            end
            default: state <= LBC_IDLE;
         endcase
      end
   end
endmodule : lbc_host

// >>> bench/lbc_checker.sv
// Checker for the serial link: idle level, clock phases, bit count, frame span.
// Assumes instantiation beside the link interface, fed by plain wires.
module lbc_checker #(
   parameter int HALF = 8
)(
   // Clock and reset.
   input wire logic mclk,
   input wire logic rst_n,
   // Link wires.
   input wire logic sclk,
   input wire logic csb_n,
   input wire logic sdi,
   input wire logic sdo
);
   logic sclk_q;
   logic [4:0] rise_cnt;
   logic [7:0] hi_cnt;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) sclk_q <= 1'b0;
      else sclk_q <= sclk;
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) rise_cnt <= 5'h0;
      else if (csb_n) rise_cnt <= 5'h0;
      else if (sclk && !sclk_q) rise_cnt <= rise_cnt + 5'h1;
   end
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) hi_cnt <= 8'h0;
      else if (!sclk) hi_cnt <= 8'h0;
      else hi_cnt <= hi_cnt + 8'h1;
   end
   // ----------------------------------------------------------------
   // Assertions.
   // ----------------------------------------------------------------
   chk_idle_clock_low: assert property (csb_n |-> !sclk)
      else $error("link clock high outside a frame");
   chk_frame_lead_low: assert property ($fell(csb_n) |-> !sclk [*6])
      else $error("link clock rose too soon after select");
   chk_clock_high_len: assert property ($fell(sclk) |-> hi_cnt == 8'(HALF))
      else $error("link clock high phase has wrong length");
   chk_clock_low_len: assert property ($fell(sclk) && !csb_n |=> !sclk [*6])
      else $error("link clock low phase too short");
   chk_data_hold_high: assert property (sclk && $past(sclk) |-> $stable(sdi))
      else $error("host data changed while link clock high");
   chk_reply_low_phase: assert property (!csb_n && $changed(sdo) |-> !sclk)
      else $error("device data changed while link clock high");
   chk_frame_bit_count: assert property ($rose(csb_n) |-> rise_cnt == 5'h10)
      else $error("frame did not carry sixteen bits");
   chk_frame_span: assert property ($fell(csb_n) |-> ##[255:275] $rose(csb_n))
      else $error("frame length out of range");
endmodule : lbc_checker

// >>> bench/tb_led_buck_current_config_regs.sv
// Testbench: controller and driver joined by the link, driven over AHB-Lite.
// Assumes the default half link period of 8 clock cycles.
module tb_led_buck_current_config_regs
   import lbc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic got = 1'b0;
   logic hsel, hwrite, hreadyout, hresp, irq, supply_above_uv_flag, link_error;
   logic range_sel_first, range_sel_second, range_sel_third;
   logic [1:0] htrans, ripple_sel_first, ripple_sel_second, ripple_sel_third;
   logic [2:0] hsize, dim, ctl, gate_drive_out;
   logic [7:0] sup, target_code_first, target_code_second, target_code_third;
   logic [7:0] uv_threshold_value, dv[0:7];
   logic [31:0] haddr, hwdata, hrdata, res, e_v;
   logic [31:0] exp_q[$];
   string nm_q[$];
   string e_n;
   int n_mismatch = 0;
   int comparisons = 0;
   int seed = 32'h4301_7271;
   // Ripple before target, all written with dimming low.
   localparam logic [6:0] ADR[0:7] = '{ADDR_RIPPLE_CH1, ADDR_RIPPLE_CH2, ADDR_RIPPLE_CH3,
      ADDR_RANGE, ADDR_UV_THRESHOLD, ADDR_TARGET_CH1, ADDR_TARGET_CH2, ADDR_TARGET_CH3};
   localparam logic [7:0] MSK[0:7] = '{RIPPLE_MASK, RIPPLE_MASK, RIPPLE_MASK, RANGE_MASK,
      8'hFF, 8'hFF, 8'hFF, 8'hFF};
   assign dv[0] = {6'h0, ripple_sel_first};
   assign dv[1] = {6'h0, ripple_sel_second};
   assign dv[2] = {6'h0, ripple_sel_third};
   assign dv[3] = {5'h0, range_sel_third, range_sel_second, range_sel_first};
   assign dv[4] = uv_threshold_value;
   assign dv[5] = target_code_first;
   assign dv[6] = target_code_second;
   assign dv[7] = target_code_third;
   lbc_link_if lbc_link_if_i();
   lbc_host lbc_host_i(.mclk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq, .link(lbc_link_if_i));
   lbc_dev lbc_dev_i(.mclk, .rst_n, .link(lbc_link_if_i), .supply_level_code(sup),
      .dim_input(dim), .dim_ctrl_en(ctl), .target_code_first, .target_code_second,
      .target_code_third, .range_sel_first, .range_sel_second, .range_sel_third,
      .ripple_sel_first, .ripple_sel_second, .ripple_sel_third, .uv_threshold_value,
      .supply_above_uv_flag, .gate_drive_out, .link_error);
   lbc_checker #(.HALF(LINK_HALF_CYC)) lbc_checker_i(.mclk, .rst_n, .sclk(lbc_link_if_i.sclk),
      .csb_n(lbc_link_if_i.csb_n), .sdi(lbc_link_if_i.sdi), .sdo(lbc_link_if_i.sdo));
   always #25 mclk = ~mclk;
   // ----------------------------------------------------------------
   // Tasks.
   // ----------------------------------------------------------------
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= HTRANS_NONSEQ;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask : ahb
   task automatic frame(input logic w, input logic [6:0] a, input logic [7:0] d,
      output logic [7:0] q);
      logic [31:0] r;
      ahb(1'b1, OFS_CMD, {16'h0, w, a, d}, r);
      r = 32'h1;
      while (r[STATUS_BUSY_BIT] !== 1'b0) ahb(1'b0, OFS_STATUS, 32'h0, r);
      q = r[15:8];
   endtask : frame
   task automatic note(input string n, input logic [31:0] e, input logic [31:0] a);
      nm_q.push_back(n);
      exp_q.push_back(e);
      res <= a;
      got <= 1'b1;
      @(posedge mclk);
      got <= 1'b0;
      @(posedge mclk);
   endtask : note
   task summarize;
      if (n_mismatch == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : summarize
   always @(negedge mclk) begin
      if (got === 1'b1) begin
         comparisons++;
         e_v = exp_q.pop_front();
         e_n = nm_q.pop_front();
         if (res !== e_v) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", e_n, e_v, res);
         end
      end
   end
   initial begin
      #2000000;
      n_mismatch++;
      summarize();
   end
   // ----------------------------------------------------------------
   // Main sequence.
   // ----------------------------------------------------------------
   initial begin
      logic [7:0] q, d;
      logic [7:0] ex[0:7];
      logic [31:0] r;
      hsel = 1'b0;
      hwrite = 1'b0;
      htrans = 2'h0;
      haddr = 32'h0;
      hwdata = 32'h0;
      hsize = 3'h2;
      sup = 8'h0;
      dim = 3'h0;
      ctl = 3'h0;
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      for (int i = 0; i < 8; i++) note("reset_cfg", {24'h0, REG_RESET}, {24'h0, dv[i]});
      ahb(1'b1, OFS_IRQ_ENABLE, 32'h1, r);
      for (int i = 0; i < 8; i++) begin
         d = (i > 4) ? 8'({$random(seed)} % 245) + 8'h01 : 8'($random(seed));
         if (ADR[i] == ADDR_RANGE) d = d & RANGE_MASK;
         frame(1'b1, ADR[i], d, q);
         ex[i] = d & MSK[i];
         note("cfg_out", {24'h0, ex[i]}, {24'h0, dv[i]});
      end
      for (int i = 0; i < 8; i++) begin
         frame(1'b0, ADR[i], 8'h0, q);
         note("link_rd", {24'h0, ex[i]}, {24'h0, q});
         note("cfg_keep", {24'h0, ex[i]}, {24'h0, dv[i]});
      end
      note("irq_on", 32'h1, {31'h0, irq});
      ahb(1'b1, OFS_IRQ_CLEAR, 32'h1, r);
      @(posedge mclk);
      note("irq_clr", 32'h0, {31'h0, irq});
      ahb(1'b1, OFS_IRQ_ENABLE, 32'h0, r);
      sup <= 8'($random(seed)) | 8'h01;
      frame(1'b0, ADDR_SUPPLY_LEVEL, 8'h0, q);
      note("supply_rd", {24'h0, sup}, {24'h0, q});
      note("irq_mask", 32'h0, {31'h0, irq});
      ahb(1'b0, OFS_IRQ_STATUS, 32'h0, r);
      note("irq_stat", 32'h1, r);
      ahb(1'b0, 8'h20, 32'h0, r);
      note("ahb_unmapped", 32'h0, r);
      frame(1'b1, ADDR_SUPPLY_LEVEL, ~sup, q);
      frame(1'b0, ADDR_SUPPLY_LEVEL, 8'h0, q);
      note("supply_ro", {24'h0, sup}, {24'h0, q});
      note("err_quiet", 32'h0, {31'h0, link_error});
      frame(1'b1, ADDR_UV_THRESHOLD, 8'h40, q);
      for (int k = 0; k < 3; k++) begin
         sup <= 8'h3F + 8'(k);
         repeat (3) @(posedge mclk);
         note("uv_flag", {31'h0, k == 2}, {31'h0, supply_above_uv_flag});
      end
      for (int j = 0; j < 64; j++) begin
         {dim, ctl} <= 6'(j);
         repeat (5) @(posedge mclk);
         note("gate", {29'h0, dim & ctl}, {29'h0, gate_drive_out});
      end
      frame(1'b1, ADDR_TARGET_CH1, 8'h22, q);
      note("live_tgt", 32'h22, {24'h0, target_code_first});
      note("gate_run", 32'h7, {29'h0, gate_drive_out});
      frame(1'b1, 7'h10, 8'h11, q);
      note("err_set", 32'h1, {31'h0, link_error});
      frame(1'b0, 7'h10, 8'h0, q);
      note("unmapped_rd", {24'h0, READ_UNMAPPED}, {24'h0, q});
      note("hresp_okay", {31'h0, HRESP_OKAY}, {31'h0, hresp});
      note("hready_out", 32'h1, {31'h0, hreadyout});
      sup <= 8'h3F;
      repeat (3) @(posedge mclk);
      note("uv_low", 32'h0, {31'h0, supply_above_uv_flag});
      note("gate_uv", 32'h0, {29'h0, gate_drive_out});
      summarize();
   end
endmodule : tb_led_buck_current_config_regs
